/* File: hw/semu_pkg.sv */
/*
  semu_pkg: shared constants of the event and mailbox unit.
  assumes: included by every design file of the unit; no other deps.
*/
package semu_pkg;

  // ----------------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------------
  localparam int unsigned SEMU_DATA_W      = 32;
  localparam int unsigned SEMU_INBOX_DEPTH = 4;
  localparam int unsigned SEMU_CNT_W       = 3;
  localparam int unsigned SEMU_CHAN_W      = 7;
  localparam int unsigned SEMU_ADDR_W      = 8;

  // ----------------------------------------------------------------------
  // element-side channel numbers
  // ----------------------------------------------------------------------
  localparam logic [6:0] SEMU_CH_EV_STATUS  = 7'h00;
  localparam logic [6:0] SEMU_CH_EV_MASK_WR = 7'h01;
  localparam logic [6:0] SEMU_CH_EV_ACK_WR  = 7'h02;
  localparam logic [6:0] SEMU_CH_EV_MASK_RD = 7'h0b;
  localparam logic [6:0] SEMU_CH_OUT_MBOX   = 7'h1c;
  localparam logic [6:0] SEMU_CH_IN_MBOX    = 7'h1d;
  localparam logic [6:0] SEMU_CH_OUT_IMBOX  = 7'h1e;

  // ----------------------------------------------------------------------
  // memory-mapped register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] SEMU_OFS_OUT_MBOX  = 8'h00;
  localparam logic [7:0] SEMU_OFS_OUT_IMBOX = 8'h04;
  localparam logic [7:0] SEMU_OFS_IN_MBOX   = 8'h08;
  localparam logic [7:0] SEMU_OFS_MBOX_STAT = 8'h0c;
  localparam logic [7:0] SEMU_OFS_PRIV_CTRL = 8'h10;
  localparam logic [7:0] SEMU_OFS_PENDING   = 8'h14;

  // privileged control: attention request bit (lsb numbering)
  localparam int unsigned SEMU_PRIV_ATTN_POS = 0;

  // ----------------------------------------------------------------------
  // event bits: bit n (msb = 0) sits at vector index 31-n
  // ----------------------------------------------------------------------
  localparam int unsigned SEMU_EV_MS   = 31 - 19;  // multisource sync
  localparam int unsigned SEMU_EV_ATTN = 31 - 20;  // privileged attention
  localparam int unsigned SEMU_EV_OUT  = 31 - 24;  // outbound available
  localparam int unsigned SEMU_EV_OUTI = 31 - 25;  // outbound intr avail
  localparam int unsigned SEMU_EV_IN   = 31 - 27;  // inbound available
  // twelve defined events; bits 0:18 and 29 reserved
  localparam logic [31:0] SEMU_EV_VALID = 32'h0000_1ffb;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] SEMU_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] SEMU_PEND_RST = 32'h0000_0000;

endpackage : semu_pkg

/* File: hw/semu_outbox.sv */
/*
  semu_outbox: one-entry mailbox holding one word.
  assumes: writer only writes while empty; reader pops by rd_en.
*/
`timescale 1ns/1ps
module semu_outbox #(
  parameter int unsigned W = 32
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         rd_en,
  output logic              full,
  output logic [W-1:0]      data
);
  import semu_pkg::*;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // write is refused while full; pop frees the slot
  always_ff @(posedge core_clk) begin
    if (reset) begin
      full <= 1'b0;
    end else if (wr_en && !full) begin
      full <= 1'b1;
    end else if (rd_en) begin
      full <= 1'b0;
    end
  end

  // data word, kept after pop
  always_ff @(posedge core_clk) begin
    if (reset) begin
      data <= '0;
    end else if (wr_en && !full) begin
      data <= wr_data;
    end
  end

endmodule : semu_outbox

/* File: hw/semu_inbox.sv */
/*
  semu_inbox: small first-in first-out mailbox queue.
  assumes: push while full is dropped; pop while empty is ignored.
*/
`timescale 1ns/1ps
module semu_inbox #(
  parameter int unsigned W     = 32,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   push,
  input  wire logic [W-1:0]           push_data,
  input  wire logic                   pop,
  output logic [W-1:0]                head,
  output logic [$clog2(DEPTH+1)-1:0]  count
);
  import semu_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic          do_push;
  logic          do_pop;

  // ----------------------------------------------------------------------
  // pointers and count
  // ----------------------------------------------------------------------
  assign do_push = push && (count != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign do_pop  = pop && (count != '0);
  assign head    = mem[rp_r];

  // pointers wrap; depth is a power of two
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wp_r  <= '0;
      rp_r  <= '0;
      count <= '0;
    end else begin
      if (do_push) wp_r <= wp_r + 1'b1;
      if (do_pop)  rp_r <= rp_r + 1'b1;
      if (do_push && !do_pop)      count <= count + 1'b1;
      else if (do_pop && !do_push) count <= count - 1'b1;
    end
  end

  // entry storage
  always_ff @(posedge core_clk) begin
    if (do_push) mem[wp_r] <= push_data;
  end

endmodule : semu_inbox

/* File: hw/semu_core.sv */
/*
  semu_core: event tracking and mailbox unit of one processing element.
  assumes: element core issues channel requests held until ch_ack;
  control processor issues one-cycle mmio strobes; single core clock.
*/
// What this block does
// - mailbox messages are 32-bit queued words
// - two one-entry outbound mailboxes, plain and interrupting
// - one four-entry inbound mailbox to element
// - outbound interrupt not ordered behind earlier commands
// - event channels 0,1,2,11 share one layout
// - 32-bit event words, twelve events, 0:18 reserved
// - sync request completion pends bit 19
// - attention request bit write pends bit 20
// - acknowledging bit 20 clears attention request
// - enabled unmasked pending event raises element interrupt
// - pending register hidden, visible to control processor
// - inbound mail arrival into an empty inbox sets mailbox event
// - status read stalls until enabled event pending
// - every event latches pending regardless of mask
// - status read returns mask AND pending
// - inbound count zero to nonzero pends bit 27
// - plain outbound mailbox read while full (full to empty) pends bit 24
`timescale 1ns/1ps
module semu_core (
  input  wire logic                              core_clk,
  input  wire logic                              reset,
  // element-side channel port
  input  wire logic                              ch_req,
  input  wire logic                              ch_wr,
  input  wire logic [semu_pkg::SEMU_CHAN_W-1:0]  ch_num,
  input  wire logic [semu_pkg::SEMU_DATA_W-1:0]  ch_wdata,
  output logic                                   ch_ack_r,
  output logic [semu_pkg::SEMU_DATA_W-1:0]       ch_rdata_r,
  output logic                                   stat_cnt_r,
  output logic [semu_pkg::SEMU_CNT_W-1:0]        inbox_cnt_r,
  // element interrupt
  input  wire logic                              elem_int_en,
  output logic                                   elem_irq_r,
  // control-processor memory-mapped port
  input  wire logic                              mmio_rd,
  input  wire logic                              mmio_wr,
  input  wire logic [semu_pkg::SEMU_ADDR_W-1:0]  mmio_addr,
  input  wire logic [semu_pkg::SEMU_DATA_W-1:0]  mmio_wdata,
  output logic                                   mmio_ack_r,
  output logic [semu_pkg::SEMU_DATA_W-1:0]       mmio_rdata_r,
  output logic                                   ctrl_irq_r,
  // event sources
  input  wire logic                              sync_done,
  input  wire logic [semu_pkg::SEMU_DATA_W-1:0]  ext_event
);
  import semu_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [31:0]           mask_r;
  logic [31:0]           pend_r;
  logic [31:0]           pend_nxt;
  logic                  attn_r;
  logic [31:0]           stat_w;
  logic                  ch_go;
  logic                  ch_ready;
  logic [31:0]           ch_rdata_nxt;
  logic [31:0]           ev_set;
  logic [31:0]           ev_clr;
  logic                  ob_full;
  logic [31:0]           ob_data;
  logic                  obi_full;
  logic [31:0]           obi_data;
  logic [31:0]           ib_head;
  logic [SEMU_CNT_W-1:0] ib_cnt;
  logic                  ob_wr;
  logic                  obi_wr;
  logic                  ob_pop;
  logic                  obi_pop;
  logic                  ib_push;
  logic                  ib_pop;
  logic                  attn_wr;
  logic [31:0]           mmio_rdata_nxt;
  logic [31:0]           mbox_stat;

  // ----------------------------------------------------------------------
  // mailbox queues
  // ----------------------------------------------------------------------
  // plain outbound mailbox, one word
  semu_outbox #(
    .W       (SEMU_DATA_W)
  ) u_out_mbox (
    .core_clk (core_clk),
    .reset    (reset),
    .wr_en    (ob_wr),
    .wr_data  (ch_wdata),
    .rd_en    (ob_pop),
    .full     (ob_full),
    .data     (ob_data)
  );

  // interrupting outbound mailbox, one word
  semu_outbox #(
    .W       (SEMU_DATA_W)
  ) u_out_imbox (
    .core_clk (core_clk),
    .reset    (reset),
    .wr_en    (obi_wr),
    .wr_data  (ch_wdata),
    .rd_en    (obi_pop),
    .full     (obi_full),
    .data     (obi_data)
  );

  // inbound mailbox, four words
  semu_inbox #(
    .W        (SEMU_DATA_W),
    .DEPTH    (SEMU_INBOX_DEPTH)
  ) u_in_mbox (
    .core_clk  (core_clk),
    .reset     (reset),
    .push      (ib_push),
    .push_data (mmio_wdata),
    .pop       (ib_pop),
    .head      (ib_head),
    .count     (ib_cnt)
  );

  // ----------------------------------------------------------------------
  // mmio strobe decode
  // ----------------------------------------------------------------------
  // outside reads pop outbound words
  assign ob_pop  = mmio_rd && (mmio_addr == SEMU_OFS_OUT_MBOX);
  assign obi_pop = mmio_rd && (mmio_addr == SEMU_OFS_OUT_IMBOX);
  // outside writes push inbound words
  assign ib_push = mmio_wr && (mmio_addr == SEMU_OFS_IN_MBOX);
  assign attn_wr = mmio_wr && (mmio_addr == SEMU_OFS_PRIV_CTRL) &&
                   mmio_wdata[SEMU_PRIV_ATTN_POS];

  // ----------------------------------------------------------------------
  // channel service
  // ----------------------------------------------------------------------
  // status seen by the element: mask AND pending
  assign stat_w = mask_r & pend_r;

  // readiness per channel; blocking reads and full writes stall
  always_comb begin
    ch_ready = 1'b1;
    if (!ch_wr && ch_num == SEMU_CH_EV_STATUS) begin
      ch_ready = |stat_w;
    end else if (!ch_wr && ch_num == SEMU_CH_IN_MBOX) begin
      ch_ready = (ib_cnt != '0);
    end else if (ch_wr && ch_num == SEMU_CH_OUT_MBOX) begin
      ch_ready = !ob_full;
    end else if (ch_wr && ch_num == SEMU_CH_OUT_IMBOX) begin
      ch_ready = !obi_full;
    end
  end

  // one service per request; the ack cycle blocks a repeat
  assign ch_go  = ch_req && ch_ready && !ch_ack_r;
  assign ob_wr  = ch_go && ch_wr && (ch_num == SEMU_CH_OUT_MBOX);
  assign obi_wr = ch_go && ch_wr && (ch_num == SEMU_CH_OUT_IMBOX);
  assign ib_pop = ch_go && !ch_wr && (ch_num == SEMU_CH_IN_MBOX);

  // read data mux over the channel numbers
  always_comb begin
    ch_rdata_nxt = '0;
    unique case (ch_num)
      SEMU_CH_EV_STATUS:  ch_rdata_nxt = stat_w;
      SEMU_CH_EV_MASK_RD: ch_rdata_nxt = mask_r;
      SEMU_CH_IN_MBOX:    ch_rdata_nxt = ib_head;
      default:            ch_rdata_nxt = '0;
    endcase
  end

  // channel answer registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ch_ack_r   <= 1'b0;
      ch_rdata_r <= '0;
    end else begin
      ch_ack_r <= ch_go;
      if (ch_go && !ch_wr) ch_rdata_r <= ch_rdata_nxt;
    end
  end

  // event mask, reserved bits held at zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mask_r <= SEMU_MASK_RST;
    end else if (ch_go && ch_wr && ch_num == SEMU_CH_EV_MASK_WR) begin
      mask_r <= ch_wdata & SEMU_EV_VALID;
    end
  end

  // ----------------------------------------------------------------------
  // event sources and pending register
  // ----------------------------------------------------------------------
  // each source pulse sets its bit, msb-first numbering
  always_comb begin
    ev_set               = ext_event & SEMU_EV_VALID;
    ev_set[SEMU_EV_MS]   = sync_done;
    ev_set[SEMU_EV_ATTN] = attn_wr;
    ev_set[SEMU_EV_OUT]  = ob_pop && ob_full;
    ev_set[SEMU_EV_OUTI] = obi_pop && obi_full;
    ev_set[SEMU_EV_IN]   = ib_push && (ib_cnt == '0);
  end

  // acknowledge clears named bits so events can fire again
  assign ev_clr = (ch_go && ch_wr && ch_num == SEMU_CH_EV_ACK_WR) ?
                  ch_wdata : '0;

  // set wins over clear; mask plays no part in latching
  assign pend_nxt = ((pend_r & ~ev_clr) | ev_set) & SEMU_EV_VALID;

  // hidden pending register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pend_r <= SEMU_PEND_RST;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // privileged attention request bit
  always_ff @(posedge core_clk) begin
    if (reset) begin
      attn_r <= 1'b0;
    end else if (attn_wr) begin
      attn_r <= 1'b1;
    end else if (ev_clr[SEMU_EV_ATTN]) begin
      attn_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // interrupts and channel counts
  // ----------------------------------------------------------------------
  // element interrupt from any enabled pending event
  always_ff @(posedge core_clk) begin
    if (reset) begin
      elem_irq_r <= 1'b0;
    end else begin
      elem_irq_r <= elem_int_en && |(mask_r & pend_nxt);
    end
  end

  // interrupt mailbox write pulse, not held for earlier commands
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_irq_r <= 1'b0;
    end else begin
      ctrl_irq_r <= obi_wr;
    end
  end

  // status and inbound channel counts
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stat_cnt_r  <= 1'b0;
      inbox_cnt_r <= '0;
    end else begin
      stat_cnt_r  <= |(mask_r & pend_nxt);
      inbox_cnt_r <= ib_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // mmio read side
  // ----------------------------------------------------------------------
  // mailbox status: outbound fulls and inbound count
  assign mbox_stat = {{(32-SEMU_CNT_W-2){1'b0}}, ib_cnt, obi_full, ob_full};

  // read mux; unmapped offsets read zero
  always_comb begin
    mmio_rdata_nxt = '0;
    unique case (mmio_addr)
      SEMU_OFS_OUT_MBOX:  mmio_rdata_nxt = ob_data;
      SEMU_OFS_OUT_IMBOX: mmio_rdata_nxt = obi_data;
      SEMU_OFS_MBOX_STAT: mmio_rdata_nxt = mbox_stat;
      SEMU_OFS_PRIV_CTRL: mmio_rdata_nxt = {31'h0, attn_r};
      SEMU_OFS_PENDING:   mmio_rdata_nxt = pend_r;
      default:            mmio_rdata_nxt = '0;
    endcase
  end

  // every strobe is answered one cycle later
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mmio_ack_r   <= 1'b0;
      mmio_rdata_r <= '0;
    end else begin
      mmio_ack_r <= mmio_rd || mmio_wr;
      if (mmio_rd) mmio_rdata_r <= mmio_rdata_nxt;
    end
  end

endmodule : semu_core

/* File: sim/semu_core_props.sv */
/*
  semu_core_props: port-level assertions for the event and mailbox unit.
  assumes: bound to semu_core; single core clock, synchronous reset.
*/
`timescale 1ns/1ps
module semu_core_props (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       ch_req,
  input wire logic       ch_wr,
  input wire logic [6:0] ch_num,
  input wire logic       ch_ack_r,
  input wire logic [31:0] ch_rdata_r,
  input wire logic [2:0] inbox_cnt_r,
  input wire logic       elem_int_en,
  input wire logic       elem_irq_r,
  input wire logic       mmio_rd,
  input wire logic       mmio_wr,
  input wire logic       mmio_ack_r,
  input wire logic       ctrl_irq_r
);
  import semu_pkg::*;
  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_mmio_ack; (mmio_rd || mmio_wr) |=> mmio_ack_r; endproperty
  a_mmio_ack: assert property (p_mmio_ack)
    else $error("mmio strobe not acknowledged");
  property p_mmio_idle; !(mmio_rd || mmio_wr) |=> !mmio_ack_r; endproperty
  a_mmio_idle: assert property (p_mmio_idle)
    else $error("mmio ack without strobe");
  property p_ch_ack; ch_ack_r |-> $past(ch_req) ##1 !ch_ack_r; endproperty
  a_ch_ack: assert property (p_ch_ack)
    else $error("channel ack not a single answered pulse");
  property p_stall;
    ch_ack_r && $past(!ch_wr && ch_num == SEMU_CH_EV_STATUS)
      |-> ch_rdata_r != 32'h0;
  endproperty
  a_stall: assert property (p_stall)
    else $error("status read finished with nothing pending");
  property p_rdata; !ch_ack_r |-> $stable(ch_rdata_r); endproperty
  a_rdata: assert property (p_rdata)
    else $error("channel read data moved without an answer");
  property p_irq_en; !elem_int_en |=> !elem_irq_r; endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("element interrupt while disabled");
  property p_ctrl_irq;
    ctrl_irq_r |-> ch_ack_r && $past(ch_wr) &&
      $past(ch_num) == SEMU_CH_OUT_IMBOX ##1 !ctrl_irq_r;
  endproperty
  a_ctrl_irq: assert property (p_ctrl_irq)
    else $error("outbound interrupt without its mailbox write");
  property p_in_max; inbox_cnt_r <= 3'h4; endproperty
  a_in_max: assert property (p_in_max)
    else $error("inbound count above four");
  property p_in_step;
    inbox_cnt_r > $past(inbox_cnt_r)
      |-> inbox_cnt_r == $past(inbox_cnt_r) + 3'h1;
  endproperty
  a_in_step: assert property (p_in_step)
    else $error("inbound count jumped");
endmodule : semu_core_props

bind semu_core semu_core_props u_props (
  .core_clk(core_clk), .reset(reset), .ch_req(ch_req), .ch_wr(ch_wr),
  .ch_num(ch_num), .ch_ack_r(ch_ack_r), .ch_rdata_r(ch_rdata_r),
  .inbox_cnt_r(inbox_cnt_r), .elem_int_en(elem_int_en),
  .elem_irq_r(elem_irq_r), .mmio_rd(mmio_rd), .mmio_wr(mmio_wr),
  .mmio_ack_r(mmio_ack_r), .ctrl_irq_r(ctrl_irq_r));

/* File: sim/semu_cpu_model.sv */
/*
  semu_cpu_model: control processor issuing mmio reads and writes.
  assumes: one-cycle strobes, ack one cycle later; driven on falling edge.
*/
`timescale 1ns/1ps
module semu_cpu_model (
  input  wire logic        core_clk,
  input  wire logic        mmio_ack_r,
  input  wire logic [31:0] mmio_rdata_r,
  output logic             mmio_rd,
  output logic             mmio_wr,
  output logic [7:0]       mmio_addr,
  output logic [31:0]      mmio_wdata
);
  // -----------------------------------------------------------------
  // access task
  // -----------------------------------------------------------------
  // idle bus at time zero
  initial begin
    mmio_rd = 1'b0;
    mmio_wr = 1'b0;
    mmio_addr = 8'h00;
    mmio_wdata = 32'h0;
  end
  // read pops outbound, write pushes inbound or sets attention
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
    int k;
    @(negedge core_clk);
    mmio_rd = !w;
    mmio_wr = w;
    mmio_addr = a;
    mmio_wdata = d;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
      mmio_rd = 1'b0;
      mmio_wr = 1'b0;
    end while (mmio_ack_r !== 1'b1 && k < 4);
    r = (k < 4) ? mmio_rdata_r : 32'hx;
    mmio_wdata = ~d;  // released data does not linger
  endtask : access
endmodule : semu_cpu_model

/* File: sim/tb_semu_core.sv */
/*
  tb_semu_core: self-checking bench for the event and mailbox unit.
  assumes: semu_pkg, semu_core and semu_cpu_model compiled before it.
*/
`timescale 1ns/1ps
module tb_semu_core;
  import semu_pkg::*;
  // -----------------------------------------------------------------
  // signals and instances
  // -----------------------------------------------------------------
  logic        core_clk, reset, ch_req, ch_wr, elem_int_en, sync_done;
  logic [6:0]  ch_num;
  logic [31:0] ch_wdata, ext_event, q, mmio_wdata, ch_rdata_r;
  logic [31:0] mmio_rdata_r;
  logic [7:0]  mmio_addr;
  logic [2:0]  inbox_cnt_r;
  logic        ch_ack_r, stat_cnt_r, elem_irq_r, mmio_rd, mmio_wr;
  logic        mmio_ack_r, ctrl_irq_r, got;
  int          fail_count, n_checks, cyc;
  semu_core dut (.core_clk(core_clk), .reset(reset), .ch_req(ch_req),
    .ch_wr(ch_wr), .ch_num(ch_num), .ch_wdata(ch_wdata),
    .ch_ack_r(ch_ack_r), .ch_rdata_r(ch_rdata_r), .stat_cnt_r(stat_cnt_r),
    .inbox_cnt_r(inbox_cnt_r), .elem_int_en(elem_int_en),
    .elem_irq_r(elem_irq_r), .mmio_rd(mmio_rd), .mmio_wr(mmio_wr),
    .mmio_addr(mmio_addr), .mmio_wdata(mmio_wdata),
    .mmio_ack_r(mmio_ack_r), .mmio_rdata_r(mmio_rdata_r),
    .ctrl_irq_r(ctrl_irq_r), .sync_done(sync_done),
    .ext_event(ext_event));
  semu_cpu_model cpu (.core_clk(core_clk), .mmio_ack_r(mmio_ack_r),
    .mmio_rdata_r(mmio_rdata_r), .mmio_rd(mmio_rd), .mmio_wr(mmio_wr),
    .mmio_addr(mmio_addr), .mmio_wdata(mmio_wdata));
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      close_out();
    end
  end
  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  function automatic logic [31:0] bitn(input int n);
    return 32'h1 << (31 - n);  // bit 0 is the msb
  endfunction : bitn
  task automatic check(input string what, input logic [31:0] exp, seen);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic chan(input logic w, input logic [6:0] n,
                      input logic [31:0] d, output logic [31:0] r);
    int k;
    @(negedge core_clk);
    ch_req = 1'b1;
    ch_wr = w;
    ch_num = n;
    ch_wdata = d;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (ch_ack_r !== 1'b1 && k < 50);
    r = (k < 50) ? ch_rdata_r : 32'hx;
    ch_req = 1'b0;
    ch_wdata = ~d;
  endtask : chan
  task automatic ev(input logic [31:0] v);
    @(negedge core_clk);
    ext_event = v;
    @(negedge core_clk);
    ext_event = 32'h0;
  endtask : ev
  task automatic pend(input logic [31:0] exp);
    cpu.access(1'b0, SEMU_OFS_PENDING, 32'h0, q);
    check("pending", exp, q);
  endtask : pend
  task automatic clr(input string s);
    chan(1'b1, SEMU_CH_EV_ACK_WR, 32'hffff_ffff, q);
    chan(1'b1, SEMU_CH_EV_MASK_WR, 32'h0, q);
    pend(32'h0);
    $display("test %s done", s);
  endtask : clr
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    {reset, ch_req, ch_wr, elem_int_en, sync_done, got} = 6'h20;
    {ch_num, ch_wdata, ext_event} = 71'h0;
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    pend(32'h0);
    chan(1'b0, SEMU_CH_EV_MASK_RD, 32'h0, q);
    check("mask reset", 32'h0, q);
    cpu.access(1'b0, 8'h40, 32'h0, q);
    check("unmapped", 32'h0, q);
    clr("reset");
    // events latch whatever the mask; status is mask and pending
    chan(1'b1, SEMU_CH_EV_MASK_WR, bitn(27), q);
    ev(bitn(31));
    pend(bitn(31));
    check("count idle", 32'h0, stat_cnt_r);
    chan(1'b1, SEMU_CH_EV_MASK_WR, bitn(27) | bitn(31), q);
    chan(1'b0, SEMU_CH_EV_STATUS, 32'h0, q);
    check("status", bitn(31), q);
    check("count set", 32'h1, stat_cnt_r);
    chan(1'b0, SEMU_CH_EV_MASK_RD, 32'h0, q);
    check("mask back", bitn(27) | bitn(31), q);
    ev(32'hffff_e000);
    pend(bitn(31));
    clr("latch");
    @(negedge core_clk) sync_done = 1'b1;
    @(negedge core_clk) sync_done = 1'b0;
    pend(bitn(19));
    clr("sync");
    cpu.access(1'b1, SEMU_OFS_PRIV_CTRL, 32'h1, q);
    pend(bitn(20));
    cpu.access(1'b0, SEMU_OFS_PRIV_CTRL, 32'h0, q);
    check("attention set", 32'h1, q);
    chan(1'b1, SEMU_CH_EV_ACK_WR, bitn(20), q);
    cpu.access(1'b0, SEMU_OFS_PRIV_CTRL, 32'h0, q);
    check("attention", 32'h0, q);
    clr("attention");
    // five pushes into four places, the last one dropped
    for (int i = 0; i < 5; i++) begin
      cpu.access(1'b1, SEMU_OFS_IN_MBOX, 32'ha0 + i, q);
    end
    check("in count", 32'h4, inbox_cnt_r);
    pend(bitn(27));
    for (int i = 0; i < 4; i++) begin
      chan(1'b0, SEMU_CH_IN_MBOX, 32'h0, q);
      check("in word", 32'ha0 + i, q);
    end
    @(negedge core_clk);
    check("in empty", 32'h0, inbox_cnt_r);
    clr("inbound");
    chan(1'b1, SEMU_CH_OUT_MBOX, 32'h1234_5678, q);
    cpu.access(1'b0, SEMU_OFS_MBOX_STAT, 32'h0, q);
    check("out full", 32'h1, q);
    cpu.access(1'b0, SEMU_OFS_OUT_MBOX, 32'h0, q);
    check("out word", 32'h1234_5678, q);
    pend(bitn(24));
    chan(1'b1, SEMU_CH_OUT_IMBOX, 32'h9abc_def0, q);
    check("ctrl irq", 32'h1, ctrl_irq_r);
    cpu.access(1'b0, SEMU_OFS_OUT_IMBOX, 32'h0, q);
    check("outi word", 32'h9abc_def0, q);
    check("ctrl irq off", 32'h0, ctrl_irq_r);
    pend(bitn(24) | bitn(25));
    clr("outbound");
    elem_int_en = 1'b1;
    chan(1'b1, SEMU_CH_EV_MASK_WR, bitn(31), q);
    ev(bitn(31));
    check("irq on", 32'h1, elem_irq_r);
    elem_int_en = 1'b0;
    repeat (2) @(negedge core_clk);
    check("irq off", 32'h0, elem_irq_r);
    clr("interrupt");
    // status read stalls until an enabled event pends
    chan(1'b1, SEMU_CH_EV_MASK_WR, bitn(30), q);
    fork
      begin
        chan(1'b0, SEMU_CH_EV_STATUS, 32'h0, q);
        got = 1'b1;
      end
      begin
        repeat (6) @(negedge core_clk);
        check("stalled", 32'h0, got);
        ev(bitn(30));
      end
    join
    check("stall status", bitn(30), q);
    clr("stall");
    // leave mask, pending and inbound state behind, then reset mid-run
    chan(1'b1, SEMU_CH_EV_MASK_WR, bitn(31), q);
    ev(bitn(31));
    cpu.access(1'b1, SEMU_OFS_IN_MBOX, 32'h55, q);
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    pend(32'h0);
    chan(1'b0, SEMU_CH_EV_MASK_RD, 32'h0, q);
    check("mask after reset", 32'h0, q);
    check("in after reset", 32'h0, inbox_cnt_r);
    $display("test midrun reset done");
    close_out();
  end
endmodule : tb_semu_core
